// File: hw/thermal_alert_defines.svh
// Purpose: Offsets, field positions and reset values of the alarm status and mask registers.
// Assumes: Included by its bare name from every file that needs a number.
// Notes: Definitions only.
`ifndef THERMAL_ALERT_DEFINES_SVH
`define THERMAL_ALERT_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define TA_STATUS_ADDR 8'h02
`define TA_MASK_ADDR 8'h16

// ****************************************
// Status and mask bit positions
// ****************************************
`define TA_BIT_BUSY 7
`define TA_BIT_LOCAL_HIGH 6
`define TA_BIT_UNUSED5 5
`define TA_BIT_REMOTE_HIGH 4
`define TA_BIT_REMOTE_LOW 3
`define TA_BIT_DIODE_FAULT 2
`define TA_BIT_REMOTE_CRIT 1
`define TA_BIT_TACH 0

// ****************************************
// Reset values and fixed patterns
// ****************************************
`define TA_STATUS_RESET 8'h00
`define TA_MASK_RESET 8'ha4
`define TA_MASK_FIXED_ONES 8'ha4
`define TA_MASK_WRITABLE 8'h5b
`define TA_ALERT_CAPABLE 8'h5b
`define TA_LATCH_BITS 8'h5f
`define TA_RDATA_UNMAPPED 8'h00
`define TA_RDATA_RESET 8'h00

`endif

// File: hw/thermal_alert_pkg.sv
// Purpose: Types shared by the alarm status and mask logic.
// Assumes: Numbers live in thermal_alert_defines.svh.
// Notes: Each hw module keeps its whole state in one of these structs.
package thermal_alert_pkg;

  // ****************************************
  // Register access from the serial port engine
  // ****************************************
  typedef struct packed {
    logic [7:0] addr;   // Register pointer
    logic [7:0] wdata;  // Write byte
    logic wr;           // One-cycle write strobe
    logic rd;           // One-cycle read strobe
  } reg_req_t;

  // ****************************************
  // Module state records
  // ****************************************
  typedef struct packed {
    logic [7:0] cond;    // Live comparison result, last conversion
    logic [7:0] status;  // Sticky alarm bits
  } latch_state_t;

  typedef struct packed {
    logic alert_n;   // Pin level while driven
    logic alert_oe;  // High while pulling the pin low
  } alert_state_t;

  typedef struct packed {
    logic [7:0] mask;   // Alarm mask register
    logic [7:0] rdata;  // Read data byte
  } top_state_t;

endpackage

// File: hw/alarm_latch.sv
// Purpose: Sticky alarm bits that hold until read, then reload from the live condition.
// Assumes: Condition and strobes come from logic on the same clock.
// Notes: A new alarm in the read cycle survives the read.
`timescale 1ns/10ps
`include "thermal_alert_defines.svh"
module alarm_latch
  import thermal_alert_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] LATCH_BITS = `TA_LATCH_BITS
)
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] cond_i,   // Fresh comparison results
  input wire logic update_i,             // Conversion complete strobe
  input wire logic clear_i,              // Status read strobe
  output logic [WIDTH-1:0] status_o,     // Sticky bits
  output logic [WIDTH-1:0] cond_o        // Live condition
);

  latch_state_t state;       // Registered state
  latch_state_t next_state;  // Next state
  logic [WIDTH-1:0] next_cond_w;
  logic [WIDTH-1:0] next_status_w;

  // ****************************************
  // Per-bit latch
  // ****************************************
  for (genvar b = 0; b < WIDTH; b++)
  begin : g_bit
    if (LATCH_BITS[b])
    begin : g_used
      // Hold live result between conversions
      assign next_cond_w[b] = update_i ? cond_i[b] : state.cond[b];
      // Read reloads from live condition; set wins over clear
      assign next_status_w[b] = (clear_i ? state.cond[b] : state.status[b]) | (update_i & cond_i[b]);
    end
    else
    begin : g_unused
      // Busy and unused bits never latch
      assign next_cond_w[b] = 1'b0;
      assign next_status_w[b] = 1'b0;
    end
  end

  // Pack next state
  always_comb
  begin
    next_state = state;
    next_state.cond = next_cond_w;
    next_state.status = next_status_w;
  end

  // State register, zero after reset
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state <= '{cond: `TA_STATUS_RESET, status: `TA_STATUS_RESET};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign status_o = state.status;
  assign cond_o = state.cond;

endmodule

// File: hw/alert_pin_ctrl.sv
// Purpose: Drives the open-drain alert pin from masked alarms.
// Assumes: Mode bit, mask and alarm vectors share the clock.
// Notes: Pin is active low; enable is high while pulling low.
`timescale 1ns/10ps
`include "thermal_alert_defines.svh"
module alert_pin_ctrl
  import thermal_alert_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] status_i,      // Sticky alarm bits
  input wire logic [7:0] cond_i,        // Live alarm condition
  input wire logic [7:0] mask_i,        // Mask register
  input wire logic comparator_mode_i,   // 1 follows live condition
  output logic alert_n_o,               // Pin level
  output logic alert_oe_o               // Pin drive enable
);

  alert_state_t state;       // Registered pin state
  alert_state_t next_state;  // Next pin state
  logic [7:0] source;        // Chosen alarm vector
  logic active;              // Any unmasked alert-capable alarm

  // Select source, apply mask and capability
  always_comb
  begin
    // Comparator mode follows live condition, else latched bits
    source = comparator_mode_i ? cond_i : status_i;
    // Mask 0 lets an alarm through; busy and diode fault excluded
    active = |(source & ~mask_i & `TA_ALERT_CAPABLE);
    next_state.alert_n = ~active;
    next_state.alert_oe = active;
  end

  // Pin register, released after reset
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state <= '{alert_n: 1'b1, alert_oe: 1'b0};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign alert_n_o = state.alert_n;
  assign alert_oe_o = state.alert_oe;

endmodule

// File: hw/thermal_alert_status_mask.sv
// Purpose: Alarm status and mask registers with open-drain alert pin control.
// Assumes: Serial port engine, converter and tachometer run on ref_clk_i.
// Notes: Comparisons are made here when a conversion result is presented.
`timescale 1ns/10ps
`include "thermal_alert_defines.svh"
module thermal_alert_status_mask
  import thermal_alert_pkg::*;
#(
  parameter int TACH_W = 16  // Tachometer count width
)
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire reg_req_t reg_req_i,               // Register access strobes
  input wire logic busy_i,                      // Converter active
  input wire logic result_valid_i,              // New conversion result strobe
  input wire logic signed [7:0] local_temp_i,   // Local temperature
  input wire logic signed [7:0] local_high_i,   // Local high limit
  input wire logic signed [10:0] remote_temp_i, // Remote temperature, 0.125 step
  input wire logic signed [10:0] remote_high_i, // Remote high limit
  input wire logic signed [10:0] remote_low_i,  // Remote low limit
  input wire logic signed [7:0] remote_crit_i,  // Remote critical limit, whole degrees
  input wire logic diode_fault_i,               // Diode open or shorted
  input wire logic [TACH_W-1:0] tach_count_i,   // Tachometer count
  input wire logic [TACH_W-1:0] tach_limit_i,   // Tachometer count limit
  input wire logic comparator_mode_i,           // Alert mode configuration bit
  output logic [7:0] reg_rdata_o,               // Read byte
  output logic alert_n_o,                       // Alert pin level
  output logic alert_oe_o                       // Alert pin drive enable
);

  // ****************************************
  // Declarations
  // ****************************************
  top_state_t state;        // Registered state
  top_state_t next_state;   // Next state
  logic [7:0] fresh_cond;   // Comparison results in status layout
  logic [7:0] status_w;     // Sticky bits
  logic [7:0] cond_w;       // Live condition
  logic [7:0] status_view;  // Status as software reads it
  logic status_read;        // Status register read strobe

  // ****************************************
  // Comparators
  // ****************************************
  always_comb
  begin
    fresh_cond = 8'h00;
    // Local strictly above high limit
    fresh_cond[`TA_BIT_LOCAL_HIGH] = local_temp_i > local_high_i;
    // Remote strictly above high limit
    fresh_cond[`TA_BIT_REMOTE_HIGH] = remote_temp_i > remote_high_i;
    // Remote strictly below low limit
    fresh_cond[`TA_BIT_REMOTE_LOW] = remote_temp_i < remote_low_i;
    // Diode connection fault
    fresh_cond[`TA_BIT_DIODE_FAULT] = diode_fault_i;
    // Integer part against critical limit
    // Whole-degree part kept signed so cold readings compare as negative
    fresh_cond[`TA_BIT_REMOTE_CRIT] = $signed(remote_temp_i[10:3]) > remote_crit_i;
    // Slow fan gives large count
    fresh_cond[`TA_BIT_TACH] = tach_count_i > tach_limit_i;
  end

  // ****************************************
  // Sticky status bits
  // ****************************************
  assign status_read = reg_req_i.rd && (reg_req_i.addr == `TA_STATUS_ADDR);

  alarm_latch #(
    .WIDTH(8),
    .LATCH_BITS(`TA_LATCH_BITS)
  ) u_latch (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .cond_i(fresh_cond),
    .update_i(result_valid_i),
    .clear_i(status_read),
    .status_o(status_w),
    .cond_o(cond_w)
  );

  // ****************************************
  // Register file
  // ****************************************
  always_comb
  begin
    status_view = status_w;
    // Busy flag read live
    status_view[`TA_BIT_BUSY] = busy_i;
    // Unused bit reads zero
    status_view[`TA_BIT_UNUSED5] = 1'b0;
    next_state = state;
    // Mask write keeps busy, unused and diode fault bits at one
    if (reg_req_i.wr && (reg_req_i.addr == `TA_MASK_ADDR))
    begin
      next_state.mask = (reg_req_i.wdata & `TA_MASK_WRITABLE) | `TA_MASK_FIXED_ONES;
    end
    // Status writes fall through untouched
    if (reg_req_i.rd)
    begin
      unique case (reg_req_i.addr)
        `TA_STATUS_ADDR: next_state.rdata = status_view; // Value before read-clear
        `TA_MASK_ADDR: next_state.rdata = state.mask | `TA_MASK_FIXED_ONES;
        default: next_state.rdata = `TA_RDATA_UNMAPPED;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state <= '{mask: `TA_MASK_RESET, rdata: `TA_RDATA_RESET};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign reg_rdata_o = state.rdata;

  // ****************************************
  // Alert pin
  // ****************************************
  alert_pin_ctrl u_pin (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .status_i(status_w),
    .cond_i(cond_w),
    .mask_i(state.mask),
    .comparator_mode_i(comparator_mode_i),
    .alert_n_o(alert_n_o),
    .alert_oe_o(alert_oe_o)
  );

endmodule

// File: tb/thermal_alert_props.sv
// Purpose: Port checks for the alarm status and mask block.
// Assumes: One clock; a read answers one cycle after its strobe.
// Notes: Shadows mask and live condition to predict the pin.
`timescale 1ns/10ps
`include "thermal_alert_defines.svh"
module thermal_alert_props
  import thermal_alert_pkg::*;
#(
  parameter int TACH_W = 16
)
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire reg_req_t reg_req_i,
  input wire logic busy_i,
  input wire logic result_valid_i,
  input wire logic signed [7:0] local_temp_i,
  input wire logic signed [7:0] local_high_i,
  input wire logic signed [10:0] remote_temp_i,
  input wire logic signed [10:0] remote_high_i,
  input wire logic signed [10:0] remote_low_i,
  input wire logic signed [7:0] remote_crit_i,
  input wire logic diode_fault_i,
  input wire logic [TACH_W-1:0] tach_count_i,
  input wire logic [TACH_W-1:0] tach_limit_i,
  input wire logic comparator_mode_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic alert_n_o,
  input wire logic alert_oe_o
);
  // ********
  // Shadow state
  // ********
  logic [7:0] mask_q; // Expected mask
  logic [7:0] live_q; // Expected live condition
  wire st_rd = reg_req_i.rd && reg_req_i.addr == `TA_STATUS_ADDR; // Status read
  wire mk_rd = reg_req_i.rd && reg_req_i.addr == `TA_MASK_ADDR; // Mask read
  wire quiet = !reg_req_i.rd && !reg_req_i.wr; // No access
  // Follow mask writes and conversion results
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mask_q <= `TA_MASK_RESET;
      live_q <= 8'h00;
    end
    else
    begin
      if (reg_req_i.wr && reg_req_i.addr == `TA_MASK_ADDR)
        mask_q <= (reg_req_i.wdata & `TA_MASK_WRITABLE) | `TA_MASK_FIXED_ONES;
      if (result_valid_i)
        live_q <= {1'b0, local_temp_i > local_high_i, 1'b0, remote_temp_i > remote_high_i,
          remote_temp_i < remote_low_i, diode_fault_i, $signed(remote_temp_i[10:3]) > remote_crit_i,
          tach_count_i > tach_limit_i};
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Two idle cycles in latched mode
  sequence quiet_two_s;
    (quiet && !comparator_mode_i) [*2];
  endsequence
  // Two status reads one idle cycle apart, with no new result
  sequence reread_s;
    (st_rd && !result_valid_i) ##1 (quiet && !result_valid_i) ##1 (st_rd && !result_valid_i);
  endsequence
  busy_flag_a: assert property (st_rd |=> reg_rdata_o[7] == $past(busy_i))
    else $error("busy flag wrong");
  unused_zero_a: assert property (st_rd |=> !reg_rdata_o[5])
    else $error("status bit 5 set");
  mask_read_a: assert property (mk_rd |=> reg_rdata_o == $past(mask_q))
    else $error("mask read wrong");
  live_alert_a: assert property ($past(comparator_mode_i) |->
    alert_n_o == !(|($past(live_q) & ~$past(mask_q) & 8'h5b))) else $error("live alert wrong");
  oe_inverse_a: assert property ((alert_oe_o == !alert_n_o) && (alert_n_o || (($past(mask_q) & 8'h5b) != 8'h5b)))
    else $error("pin enable wrong");
  latched_hold_a: assert property (quiet ##1 (!alert_n_o ##0 quiet_two_s) |=> !alert_n_o)
    else $error("latched alert released");
  sticky_reread_a: assert property (reread_s |=> reg_rdata_o[6:0] == $past(live_q[6:0]))
    else $error("reread status wrong");
  unmapped_read_a: assert property (reg_req_i.rd && !st_rd && !mk_rd |=> reg_rdata_o == 8'h00)
    else $error("unmapped read wrong");
endmodule

// File: tb/smbus_host_model.sv
// Purpose: Host side of the register port.
// Assumes: Strobes taken on the rising edge.
// Notes: Released address and data show inverted values.
`timescale 1ns/10ps
module smbus_host_model
  import thermal_alert_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic [7:0] rdata_i,
  output reg_req_t req_o
);
  initial req_o = '0;
  // One-byte write
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    req_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  // One-byte read, data one cycle later
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    req_o <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
    @(negedge ref_clk_i);
    d = rdata_i;
  endtask
endmodule

// File: tb/test_thermal_alert_status_mask.sv
// Purpose: Self-checking bench for the alarm status and mask block.
// Assumes: Limits held fixed; results change one case at a time.
// Notes: Alert pin checked two edges after its cause.
`timescale 1ns/10ps
module test_thermal_alert_status_mask;
  import thermal_alert_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  reg_req_t reg_req_i;
  logic busy_i = 1'b0;
  logic result_valid_i = 1'b0;
  logic signed [7:0] local_temp_i = 8'sh28;
  logic signed [7:0] local_high_i = 8'sh28;
  logic signed [10:0] remote_temp_i = 11'sh190;
  logic signed [10:0] remote_high_i = 11'sh190;
  logic signed [10:0] remote_low_i = 11'sh050;
  logic signed [7:0] remote_crit_i = 8'sh3c;
  logic diode_fault_i = 1'b0;
  logic [15:0] tach_count_i = 16'h03e8;
  logic [15:0] tach_limit_i = 16'h03e8;
  logic comparator_mode_i = 1'b1;
  logic [7:0] reg_rdata_o;
  logic alert_n_o;
  logic alert_oe_o;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] d; // Read byte
  // One case per alert-capable alarm; limits sit at the boundary values
  logic [7:0] lt_t[5] = '{8'h29, 8'h28, 8'h28, 8'h28, 8'h28};
  logic [10:0] rt_t[5] = '{11'h190, 11'h191, 11'h04f, 11'h1e8, 11'h190};
  logic [15:0] tc_t[5] = '{16'h03e8, 16'h03e8, 16'h03e8, 16'h03e8, 16'h03e9};
  logic [7:0] ex_t[5] = '{8'h40, 8'h10, 8'h08, 8'h12, 8'h01};
  thermal_alert_status_mask thermal_alert_status_mask_i (.*);
  smbus_host_model smbus_host_model_i (.ref_clk_i(ref_clk_i), .rdata_i(reg_rdata_o), .req_o(reg_req_i));
  initial
  begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  // Hang guard
  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Wait past the pin update, then compare
  task automatic pin(input logic exp);
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check("alert pin", {7'h00, alert_n_o}, {7'h00, exp});
    check("alert enable", {7'h00, alert_oe_o}, {7'h00, ~exp});
  endtask
  // Present one conversion result
  task automatic convert(input logic [7:0] lt, input logic [10:0] rt, input logic [15:0] tc, input logic df);
    @(posedge ref_clk_i);
    local_temp_i <= lt;
    remote_temp_i <= rt;
    tach_count_i <= tc;
    diode_fault_i <= df;
    result_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    result_valid_i <= 1'b0;
  endtask
  task automatic t_reset_and_mask();
    smbus_host_model_i.get(8'h02, d);
    check("status reset", d, 8'h00);
    smbus_host_model_i.get(8'h16, d);
    check("mask reset", d, 8'ha4);
    smbus_host_model_i.put(8'h16, 8'hff);
    smbus_host_model_i.get(8'h16, d);
    check("mask ones", d, 8'hff);
    smbus_host_model_i.put(8'h16, 8'h00);
    smbus_host_model_i.get(8'h16, d);
    check("mask zeros", d, 8'ha4);
    smbus_host_model_i.put(8'h02, 8'hff);
    smbus_host_model_i.get(8'h02, d);
    check("status write", d, 8'h00);
    smbus_host_model_i.get(8'h55, d);
    check("unmapped read", d, 8'h00);
  endtask
  task automatic t_each_alarm();
    for (int i = 0; i < 5; i++)
    begin
      @(posedge ref_clk_i);
      busy_i <= i[0];
      convert(lt_t[i], rt_t[i], tc_t[i], 1'b0);
      pin(1'b0);
      smbus_host_model_i.get(8'h02, d);
      check("alarm status", d, ex_t[i] | {i[0], 7'h00});
      smbus_host_model_i.put(8'h16, ex_t[i]);
      pin(1'b1);
      smbus_host_model_i.put(8'h16, 8'h00);
      convert(8'h28, 11'h190, 16'h03e8, 1'b0);
      pin(1'b1);
      smbus_host_model_i.get(8'h02, d);
      smbus_host_model_i.get(8'h02, d);
      check("cleared status", d, {i[0], 7'h00});
    end
    @(posedge ref_clk_i);
    busy_i <= 1'b0;
  endtask
  task automatic t_diode_fault();
    convert(8'h28, 11'h190, 16'h03e8, 1'b1);
    pin(1'b1);
    smbus_host_model_i.get(8'h02, d);
    check("fault status", d, 8'h04);
    convert(8'h28, 11'h190, 16'h03e8, 1'b0);
    smbus_host_model_i.get(8'h02, d);
    check("fault held", d, 8'h04);
  endtask
  task automatic t_latched();
    comparator_mode_i <= 1'b0;
    convert(8'h29, 11'h190, 16'h03e8, 1'b0);
    convert(8'h28, 11'h190, 16'h03e8, 1'b0);
    pin(1'b0);
    smbus_host_model_i.get(8'h02, d);
    check("latched status", d, 8'h40);
    pin(1'b1);
    smbus_host_model_i.get(8'h02, d);
    check("latched cleared", d, 8'h00);
    @(posedge ref_clk_i);
    comparator_mode_i <= 1'b1;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_reset_and_mask();
    t_each_alarm();
    t_diode_fault();
    t_latched();
    summarize();
  end
endmodule
bind thermal_alert_status_mask thermal_alert_props #(.TACH_W(TACH_W)) thermal_alert_props_i (.*);
